// file: verilog/reference_clock_output_control.sv
// Reference clock selection, trimming and prescaled clock output control
//
// Function
// - The output clock is the 16 MHz raw reference divided to 8, 4, 2, 1 MHz, 250 kHz or the symbol rate.
// - Rate code 0 stops the output low, 1 to 4 pick 1 to 8 MHz, 5 also gives 8 MHz, 6 picks 250 kHz, 7 the symbol rate.
// - With deferral off, or a zero rate before the write, a rate write takes effect at once.
// - With deferral on and nonzero rates before and after the write, the new rate waits for the next sleep exit.
// - Reset keeps the output at its old rate while the rate field reads back as 1.
// - Without a rewrite after reset the output drops to 1 MHz after the next sleep cycle.
// - The deferral bit resets to 1.
// - The clock drive field gives 2, 4, 6, 8 mA for codes 0 to 3 and resets to code 1.
// - The control register holds general drive 7:6, clock drive 5:4, deferral bit 3, rate 2:0.
// - The oscillator control register selects crystal or external reference mode.
// - A four-bit trim field selects 0 to 4.5 pF load capacitance in 0.3 pF steps.
// - Clock jitter, when enabled, applies to receiver logic and outputs, not to the transmitter.
`timescale 1ns/1ps
`default_nettype none
module reference_clock_output_control (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Power state
  input  wire logic       sleep_exit,
  // Clock output pin
  output logic            master_clock_out,
  output logic [1:0]      out_clock_drive_strength,
  output logic [1:0]      general_drive_strength,
  // Oscillator controls
  output logic            crystal_oscillator_enable,
  output logic [3:0]      load_cap_trim,
  // Jitter controls
  output logic            rx_jitter_enable,
  output logic            out_jitter_enable
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] osc_ff;
  logic [7:0] nxt_osc;
  logic [7:0] rx_ff;
  logic [7:0] nxt_rx;
  logic [7:0] sub_ff;
  logic [7:0] nxt_sub;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [2:0] active_ff;   // Rate driving the pin; survives reset
  logic [2:0] nxt_active;
  logic       seen_ff;     // Active rate captured after first reset
  logic       nxt_seen;
  logic [3:0] tick_ff;
  logic [3:0] nxt_tick;
  logic       raw_tick;
  logic       div_level;
  logic       first_init;  // First reset ever: clears the free-running tick
  logic       clk_out_ff;
  logic [1:0] cdrv_ff;
  logic [1:0] gdrv_ff;
  logic       crystal_oscillator_ff;
  logic [3:0] trim_ff;
  logic       rxj_ff;
  logic       outj_ff;

  logic       wr_ctrl;
  logic [2:0] old_rate;
  logic [2:0] new_rate;

  assign wr_ctrl  = reg_write && (reg_addr == clock_output_pkg::OUT_CTRL_OFFSET);
  assign old_rate = ctrl_ff[clock_output_pkg::RATE_LSB +: 3];
  assign new_rate = reg_wdata[clock_output_pkg::RATE_LSB +: 3];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_osc  = osc_ff;
    nxt_rx   = rx_ff;
    nxt_sub  = sub_ff;
    if (!rst_n) begin
      nxt_ctrl = clock_output_pkg::OUT_CTRL_RESET;
      nxt_osc  = clock_output_pkg::OSC_CTRL_RESET;
      nxt_rx   = clock_output_pkg::RX_CTRL_RESET;
      nxt_sub  = clock_output_pkg::SUB_CTRL_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        clock_output_pkg::OUT_CTRL_OFFSET: nxt_ctrl = reg_wdata;
        clock_output_pkg::OSC_CTRL_OFFSET: nxt_osc  = reg_wdata;
        clock_output_pkg::RX_CTRL_OFFSET:  nxt_rx   = reg_wdata;
        clock_output_pkg::SUB_CTRL_OFFSET: nxt_sub  = reg_wdata;
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path; unmapped addresses read as zero
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = rdata_ff;
    if (!rst_n) begin
      nxt_rdata = 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        clock_output_pkg::OUT_CTRL_OFFSET: nxt_rdata = ctrl_ff;
        clock_output_pkg::OSC_CTRL_OFFSET: nxt_rdata = osc_ff;
        clock_output_pkg::RX_CTRL_OFFSET:  nxt_rdata = rx_ff;
        clock_output_pkg::SUB_CTRL_OFFSET: nxt_rdata = sub_ff;
        default:                           nxt_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Active rate shadow. Only the first reset ever loads it, so the pin keeps its
  // rate; only a write or a sleep exit moves it.
  // ----------------------------------------------------------------
  always_comb begin
    nxt_active = active_ff;
    nxt_seen   = seen_ff;
    first_init = 1'b0;
    if (!rst_n) begin
      // Before the first reset ever the flag is unknown and lands in the
      // default; later resets leave the pin rate alone
      case (seen_ff)
        1'b1: nxt_seen = 1'b1;
        default: begin
          nxt_active = clock_output_pkg::RATE_RESET;
          nxt_seen   = 1'b1;
          first_init = 1'b1;
        end
      endcase
    end else if (wr_ctrl &&
                 (!reg_wdata[clock_output_pkg::DEFER_BIT] ||
                  old_rate == clock_output_pkg::RATE_OFF ||
                  new_rate == clock_output_pkg::RATE_OFF)) begin
      nxt_active = new_rate;
    end else if (sleep_exit) begin
      nxt_active = old_rate;
    end
  end

  // ----------------------------------------------------------------
  // Raw 16 MHz tick from the 250 MHz clock; the ratio is not whole,
  // so the tick uses 15 cycles and runs slightly fast, accepted for this model.
  // ----------------------------------------------------------------
  always_comb begin
    raw_tick = (tick_ff == 4'(clock_output_pkg::RAW_TICK_CYCLES - 1));
    nxt_tick = (raw_tick || first_init) ? 4'h0 : tick_ff + 4'h1;
  end

  // ----------------------------------------------------------------
  // Output pins and analog controls, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    ctrl_ff   <= nxt_ctrl;
    osc_ff    <= nxt_osc;
    rx_ff     <= nxt_rx;
    sub_ff    <= nxt_sub;
    rdata_ff  <= nxt_rdata;
    active_ff <= nxt_active;
    seen_ff   <= nxt_seen;
    tick_ff   <= nxt_tick;
    // The divider stops low itself; forcing low here could cut a high phase
    clk_out_ff <= div_level;
    cdrv_ff <= ctrl_ff[clock_output_pkg::CLK_DRIVE_LSB +: 2];
    gdrv_ff <= ctrl_ff[clock_output_pkg::GEN_DRIVE_LSB +: 2];
    crystal_oscillator_ff <= (osc_ff[clock_output_pkg::MODE_LSB +: 4] != clock_output_pkg::MODE_EXTERNAL);
    trim_ff <= osc_ff[clock_output_pkg::TRIM_LSB +: 4];
    rxj_ff  <= rx_ff[clock_output_pkg::JITTER_BIT];
    outj_ff <= rx_ff[clock_output_pkg::JITTER_BIT];
  end

  // ----------------------------------------------------------------
  // Divider instance
  // ----------------------------------------------------------------
  rate_divider u_div (
    .clock      (clock),
    .rst_n      (rst_n),
    .raw_tick   (raw_tick),
    .rate       (active_ff),
    .sub_modsel (sub_ff[clock_output_pkg::MODSEL_BIT]),
    .sub_mode   (sub_ff[clock_output_pkg::SUBMODE_BIT]),
    .clk_level  (div_level),
    .rate_taken ()
  );

  assign reg_rdata                 = rdata_ff;
  assign master_clock_out          = clk_out_ff;
  assign out_clock_drive_strength  = cdrv_ff;
  assign general_drive_strength    = gdrv_ff;
  assign crystal_oscillator_enable = crystal_oscillator_ff;
  assign load_cap_trim             = trim_ff;
  assign rx_jitter_enable          = rxj_ff;
  assign out_jitter_enable         = outj_ff;

endmodule
`default_nettype wire

// file: verilog/clock_output_pkg.sv
// Constants shared by the reference clock output control block
package clock_output_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT_CTRL_OFFSET   = 8'h03; // output_drive_and_clock_rate_control
  localparam logic [7:0] OSC_CTRL_OFFSET   = 8'h12; // oscillator_control_reg
  localparam logic [7:0] RX_CTRL_OFFSET    = 8'h0a; // jitter control
  localparam logic [7:0] SUB_CTRL_OFFSET   = 8'h0c; // modulation bits

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GEN_DRIVE_LSB    = 6;
  localparam int CLK_DRIVE_LSB    = 4;
  localparam int DEFER_BIT        = 3;
  localparam int RATE_LSB         = 0;
  localparam int MODE_LSB         = 4;
  localparam int TRIM_LSB         = 0;
  localparam int JITTER_BIT       = 5;
  localparam int MODSEL_BIT       = 3;
  localparam int SUBMODE_BIT      = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT_CTRL_RESET = 8'h19;
  localparam logic [7:0] OSC_CTRL_RESET = 8'hf0;
  localparam logic [7:0] RX_CTRL_RESET  = 8'h10;
  localparam logic [7:0] SUB_CTRL_RESET = 8'h20;
  localparam logic [2:0] RATE_RESET     = 3'h1;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] RATE_OFF     = 3'h0;
  localparam logic [2:0] RATE_1M      = 3'h1;
  localparam logic [2:0] RATE_2M      = 3'h2;
  localparam logic [2:0] RATE_4M      = 3'h3;
  localparam logic [2:0] RATE_8M      = 3'h4;
  localparam logic [2:0] RATE_16M     = 3'h5;
  localparam logic [2:0] RATE_250K    = 3'h6;
  localparam logic [2:0] RATE_SYMBOL  = 3'h7;
  localparam logic [3:0] MODE_EXTERNAL = 4'h4;
  localparam logic [3:0] MODE_CRYSTAL  = 4'hf;

  // ----------------------------------------------------------------
  // Timing: raw reference and half periods in raw ticks
  // ----------------------------------------------------------------
  localparam int RAW_REF_KHZ = 16000;
  localparam int CLOCK_KHZ   = 250000;
  localparam int RAW_TICK_CYCLES = CLOCK_KHZ / RAW_REF_KHZ; // 15 (rounded down)
  localparam logic [9:0] HALF_1M    = 10'h008;
  localparam logic [9:0] HALF_2M    = 10'h004;
  localparam logic [9:0] HALF_4M    = 10'h002;
  localparam logic [9:0] HALF_8M    = 10'h001;
  localparam logic [9:0] HALF_250K  = 10'h020;
  localparam logic [9:0] HALF_SYM20 = 10'h190; // 20 kHz
  localparam logic [9:0] HALF_SYM40 = 10'h0c8; // 40 kHz
  localparam logic [9:0] HALF_SYM25 = 10'h140; // 25 kHz
  localparam logic [9:0] HALF_SYM62 = 10'h080; // 62.5 kHz

endpackage

// file: verilog/rate_divider.sv
// Glitch-free divider producing the clock output from raw ticks
`timescale 1ns/1ps
`default_nettype none
module rate_divider (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Control
  input  wire logic       raw_tick,
  input  wire logic [2:0] rate,
  input  wire logic       sub_modsel,
  input  wire logic       sub_mode,
  // Output
  output logic            clk_level,
  output logic            rate_taken
);

  logic [9:0] cnt_ff;
  logic [9:0] nxt_cnt;
  logic       lvl_ff;
  logic       nxt_lvl;
  logic [2:0] live_ff;
  logic [2:0] nxt_live;
  logic [9:0] half;
  logic       init_ff;
  logic       first_init;

  // ----------------------------------------------------------------
  // Half period lookup for the rate in use
  // ----------------------------------------------------------------
  always_comb begin
    case (live_ff)
      clock_output_pkg::RATE_1M:   half = clock_output_pkg::HALF_1M;
      clock_output_pkg::RATE_2M:   half = clock_output_pkg::HALF_2M;
      clock_output_pkg::RATE_4M:   half = clock_output_pkg::HALF_4M;
      clock_output_pkg::RATE_8M:   half = clock_output_pkg::HALF_8M;
      clock_output_pkg::RATE_250K: half = clock_output_pkg::HALF_250K;
      clock_output_pkg::RATE_SYMBOL: begin
        case ({sub_modsel, sub_mode})
          2'h0:    half = clock_output_pkg::HALF_SYM20;
          2'h1:    half = clock_output_pkg::HALF_SYM40;
          2'h2:    half = clock_output_pkg::HALF_SYM25;
          default: half = clock_output_pkg::HALF_SYM62;
        endcase
      end
      default:     half = clock_output_pkg::HALF_8M;
    endcase
  end

  // ----------------------------------------------------------------
  // Divider; a new rate is adopted at a falling edge, or at once while stopped or stopping low, so that no
  // runt pulse reaches the pin. Rate 5 has no entry and uses the 8 MHz half period.
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_lvl  = lvl_ff;
    nxt_live = live_ff;
    rate_taken = 1'b0;
    if ((live_ff == clock_output_pkg::RATE_OFF) ||
        (rate == clock_output_pkg::RATE_OFF && !lvl_ff)) begin
      // Stopping while low is safe at once: the pin is already low
      nxt_lvl  = 1'b0;
      nxt_live = rate;
      nxt_cnt  = 10'h000;
      rate_taken = 1'b1;
    end else if (raw_tick) begin
      if (cnt_ff + 10'h001 >= half) begin
        nxt_cnt = 10'h000;
        nxt_lvl = ~lvl_ff;
        if (lvl_ff) begin
          nxt_live   = rate;
          rate_taken = 1'b1;
        end
      end else begin
        nxt_cnt = cnt_ff + 10'h001;
      end
    end
  end

  // Only the very first reset clears the divider; later resets must not
  // disturb a running pin. An unknown flag falls into the case default.
  always_comb begin
    first_init = 1'b0;
    if (!rst_n) begin
      case (init_ff)
        1'b1:    first_init = 1'b0;
        default: first_init = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (first_init) begin
      cnt_ff  <= 10'h000;
      lvl_ff  <= 1'b0;
      live_ff <= clock_output_pkg::RATE_OFF;
      init_ff <= 1'b1;
    end else begin
      cnt_ff  <= nxt_cnt;
      lvl_ff  <= nxt_lvl;
      live_ff <= nxt_live;
      init_ff <= init_ff;
    end
  end

  assign clk_level = lvl_ff;

endmodule
`default_nettype wire

// file: sim/clock_output_assertions.sv
// Port checker for the reference clock output control block
`timescale 1ns/1ps
`default_nettype none
module clock_output_assertions (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Outputs
  input wire logic       master_clock_out,
  input wire logic [1:0] out_clock_drive_strength,
  input wire logic [1:0] general_drive_strength,
  input wire logic       crystal_oscillator_enable,
  input wire logic [3:0] load_cap_trim,
  input wire logic       rx_jitter_enable,
  input wire logic       out_jitter_enable
);
  // Phase length; saturates so a stopped pin never wraps into a fake runt
  logic [12:0] phase_ff;
  logic [12:0] nxt_phase;
  logic        seen_ff;
  logic        nxt_seen;
  logic        pin_ff;
  logic        edge_now;
  assign edge_now = master_clock_out != pin_ff;
  always_comb begin
    nxt_phase = edge_now ? 13'h0 : phase_ff + {12'h0, phase_ff != 13'h1fff};
    nxt_seen  = seen_ff | edge_now;
  end
  always_ff @(posedge clock) begin
    pin_ff   <= master_clock_out;
    phase_ff <= rst_n ? nxt_phase : 13'h0;
    seen_ff  <= rst_n & nxt_seen;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_no_runt_pulse: assert property (
    seen_ff && edge_now |-> phase_ff >= 13'h00e) else $error("runt phase on pin");
  a_stop_holds_low: assert property (
    reg_write && reg_addr == 8'h03 && reg_wdata[2:0] == 3'h0 && !master_clock_out
    |-> ##3 (!master_clock_out) [*8]) else $error("stopped pin not low");
  a_clk_drive_write: assert property (
    reg_write && reg_addr == 8'h03
    |-> ##2 out_clock_drive_strength == $past(reg_wdata[5:4], 2)) else $error("clock drive");
  a_gen_drive_write: assert property (
    reg_write && reg_addr == 8'h03
    |-> ##2 general_drive_strength == $past(reg_wdata[7:6], 2)) else $error("general drive");
  a_trim_write: assert property (
    reg_write && reg_addr == 8'h12
    |-> ##2 load_cap_trim == $past(reg_wdata[3:0], 2)) else $error("trim field");
  a_osc_mode_write: assert property (
    reg_write && reg_addr == 8'h12
    |-> ##2 crystal_oscillator_enable == ($past(reg_wdata[7:4], 2) != 4'h4))
    else $error("oscillator mode");
  a_jitter_write: assert property (
    reg_write && reg_addr == 8'h0a
    |-> ##2 out_jitter_enable == $past(reg_wdata[5], 2)) else $error("jitter enable");
  a_jitter_pair: assert property (
    rx_jitter_enable == out_jitter_enable) else $error("jitter enables differ");
  a_reset_outputs: assert property (
    $rose(rst_n) |-> out_clock_drive_strength == 2'h1 && general_drive_strength == 2'h0
    && crystal_oscillator_enable && load_cap_trim == 4'h0 && !out_jitter_enable)
    else $error("outputs not at reset values");
  a_unmapped_read: assert property (
    reg_read && !(reg_addr inside {8'h03, 8'h0a, 8'h0c, 8'h12}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind reference_clock_output_control clock_output_assertions chk_u (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .master_clock_out(master_clock_out), .out_clock_drive_strength(out_clock_drive_strength),
  .general_drive_strength(general_drive_strength),
  .crystal_oscillator_enable(crystal_oscillator_enable), .load_cap_trim(load_cap_trim),
  .rx_jitter_enable(rx_jitter_enable), .out_jitter_enable(out_jitter_enable));
`default_nettype wire

// file: sim/host_clock_sink.sv
// Host model: measures one high phase of the received clock
`timescale 1ns/1ps
`default_nettype none
module host_clock_sink #(
  parameter int STOP_LIMIT = 13000
) (
  // Sampling clock and received clock
  input  wire logic   clock,
  input  wire logic   clk_pin,
  // Request and result
  input  wire logic   arm,
  output logic        meas_valid,
  output logic [15:0] meas_half
);
  logic pin_d = 1'b0;
  logic busy  = 1'b0;
  logic high  = 1'b0;
  int   cnt   = 0;
  // A pin with no rising edge within the limit is reported as stopped
  always @(posedge clock) begin
    meas_valid <= 1'b0;
    pin_d <= clk_pin;
    cnt <= cnt + 1;
    if (arm) begin
      busy <= 1'b1;
      high <= 1'b0;
      cnt <= 0;
    end else if (busy && !high && clk_pin && !pin_d) begin
      high <= 1'b1;
      cnt <= 1;
    end else if (busy && (high ? !clk_pin : cnt >= STOP_LIMIT)) begin
      meas_valid <= 1'b1;
      meas_half <= high ? 16'(cnt) : 16'h0000;
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: sim/reference_clock_output_control_tb.sv
// Self-checking bench for the reference clock output control block
`timescale 1ns/1ps
`default_nettype none
module reference_clock_output_control_tb;
  // ------------------------------
  // Stimulus, outputs and queues
  // ------------------------------
  logic        clock      = 1'b0;
  logic        rst_n      = 1'b0;
  logic [7:0]  reg_addr   = 8'h00;
  logic        reg_write  = 1'b0;
  logic        reg_read   = 1'b0;
  logic [7:0]  reg_wdata  = 8'h00;
  logic        sleep_exit = 1'b0;
  logic        arm        = 1'b0;
  logic        rd_due     = 1'b0;
  logic [7:0]  reg_rdata;
  logic        master_clock_out;
  logic        meas_valid;
  logic [15:0] meas_half;
  logic [3:0]  trim;
  logic        osc_en;
  logic        rx_jit;
  logic        out_jit;
  logic [7:0]  v;
  logic [7:0]  exp_rd[$];
  logic [15:0] exp_half[$];
  logic [9:0]  sym[4] = '{10'h190, 10'h0c8, 10'h140, 10'h080};
  int          ord[4] = '{3, 1, 2, 0};
  int          cur    = 120;
  int          n_errors = 0;
  int          checks   = 0;
  initial forever #2 clock = ~clock;
  reference_clock_output_control dut_u (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sleep_exit(sleep_exit), .master_clock_out(master_clock_out),
    .out_clock_drive_strength(), .general_drive_strength(),
    .crystal_oscillator_enable(osc_en), .load_cap_trim(trim),
    .rx_jitter_enable(rx_jit), .out_jitter_enable(out_jit));
  host_clock_sink #(.STOP_LIMIT(13000)) host_u (.clock(clock), .clk_pin(master_clock_out),
    .arm(arm), .meas_valid(meas_valid), .meas_half(meas_half));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic fail(input string m);
    n_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] e, input string m);
    checks++;
    if (got !== e) fail(m);
  endtask
  // One register access; a read queues its expected data
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w) exp_rd.push_back(d);
    reg_addr  = a;
    reg_wdata = d;
    reg_write = w;
    reg_read  = !w;
    tick(1);
    reg_write = 1'b0;
    reg_read  = 1'b0;
    tick(1);
  endtask
  task automatic pulse_sleep;
    sleep_exit = 1'b1;
    tick(1);
    sleep_exit = 1'b0;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    tick(16);
    rst_n = 1'b1;
  endtask
  // Waits one old period so the divider has taken the rate, then asks the host
  task automatic meas(input logic [9:0] h);
    int n;
    n = 0;
    tick(2 * cur + 40);
    cur = h * clock_output_pkg::RAW_TICK_CYCLES;
    exp_half.push_back(16'(cur));
    arm = 1'b1;
    tick(1);
    arm = 1'b0;
    while (meas_valid !== 1'b1 && n < 20000) begin
      tick(1);
      n++;
    end
    if (n == 20000) fail("no measurement");
    tick(1);
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Read data is due one cycle after the strobe is taken
  always @(negedge clock) begin
    if (rd_due && exp_rd.size() > 0) begin
      checks++;
      if (reg_rdata !== exp_rd.pop_front()) fail("read data");
    end
    rd_due = reg_read;
    if (meas_valid === 1'b1 && exp_half.size() > 0) begin
      checks++;
      if (meas_half !== exp_half.pop_front()) fail("half period");
    end
  end
  initial begin
    void'($urandom(2165));
    do_reset();
    acc(0, 8'h03, 8'h19);
    acc(0, 8'h12, 8'hf0);
    acc(0, 8'h0a, 8'h10);
    acc(0, 8'h0c, 8'h20);
    acc(1, 8'h40, 8'h5a);
    acc(0, 8'h40, 8'h00);
    meas(10'h008);
    v = {2'($urandom), 2'($urandom), 4'h5};
    acc(1, 8'h03, v);
    acc(0, 8'h03, v);
    meas(10'h001);
    // Reset keeps the pin rate until a sleep exit; the field reads back as 1
    do_reset();
    acc(0, 8'h03, 8'h19);
    meas(10'h001);
    pulse_sleep();
    meas(10'h008);
    acc(1, 8'h03, 8'h0b);
    acc(0, 8'h03, 8'h0b);
    meas(10'h008);
    pulse_sleep();
    meas(10'h002);
    // Stopping and restarting ignore deferral
    while (master_clock_out !== 1'b0) tick(1);
    acc(1, 8'h03, 8'h08);
    meas(10'h000);
    chk(8'(master_clock_out), 8'h00, "pin not low");
    acc(1, 8'h03, 8'h0e);
    meas(10'h020);
    for (int r = 1; r < 6; r++) begin
      acc(1, 8'h03, 8'(r));
      meas(r == 5 ? 10'h001 : 10'h008 >> (r - 1));
    end
    // Symbol rates; fast ones first keeps the settling waits short
    foreach (ord[i]) begin
      acc(1, 8'h0c, 8'h20 | 8'(ord[i] << 2));
      if (i == 0) acc(1, 8'h03, 8'h07);
      meas(sym[ord[i]]);
    end
    v = {4'h4, 4'($urandom)};
    acc(1, 8'h12, v);
    acc(0, 8'h12, v);
    chk(8'(osc_en), 8'h00, "crystal on");
    chk(8'(trim), {4'h0, v[3:0]}, "trim");
    acc(1, 8'h12, {4'hf, v[3:0]});
    chk(8'(osc_en), 8'h01, "crystal off");
    acc(1, 8'h0a, 8'h30);
    chk({6'h00, rx_jit, out_jit}, 8'h03, "jitter");
    acc(0, 8'h0a, 8'h30);
    do_reset();
    acc(1, 8'h03, 8'h07);
    acc(0, 8'h03, 8'h07);
    acc(1, 8'h03, 8'h00);
    tick(20);
    give_verdict();
  end
  // Watchdog only a little above the longest expected run
  initial begin
    repeat (95000) @(posedge clock);
    fail("timeout");
    give_verdict();
  end
endmodule
`default_nettype wire
